/* trs_pkg.sv */
package trs_pkg;

  // ==========================================================
  // clock and sample timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int SAMPLE_PERIOD_US = 500;
  localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_US * 1000000) / CLK_PERIOD_PS;
  // filter time is in 0.01 ms steps; one averaging slot per sample period
  localparam int FILTER_STEP_CS = SAMPLE_PERIOD_US / 10;
  localparam int WIN_DEPTH = 64;

  // ==========================================================
  // selector codes
  localparam logic [3:0] MODE_TORQUE = 4'h2;
  localparam logic [2:0] SRC_A = 3'h0;
  localparam logic [2:0] SRC_B = 3'h1;
  localparam logic [2:0] SRC_SUM = 3'h2;
  localparam logic [2:0] SRC_SWAP = 3'h3;
  localparam logic [2:0] SRC_COMM = 3'h4;
  localparam logic [1:0] AB_DIGITAL = 2'h0;
  localparam logic [1:0] AB_AIN1 = 2'h1;
  localparam logic [1:0] AB_AIN2 = 2'h2;
  localparam logic [1:0] AUTO_OFF = 2'h0;
  localparam logic [1:0] AUTO_AIN1 = 2'h1;
  localparam logic [1:0] AUTO_AIN2 = 2'h2;

  // ==========================================================
  // setting ranges (digital 0.1 %, comm 0.001 %, drift and dead zone 0.1 mV)
  localparam int DIGITAL_MAX = 3000;
  localparam int COMM_MAX = 100000;
  localparam int DRIFT_MAX = 5000;
  localparam int OFFSET_MAX = 5000;
  localparam int DEAD_MAX = 10000;
  localparam int FS_MIN = 100;
  localparam int FS_MAX = 800;
  localparam logic [9:0] FS_RESET = 10'h064;
  // full scale 10000 mV; 0.1 mV * 0.01 times -> 0.001 % needs division by 100
  localparam int FULL_SCALE_MV = 10000;
  localparam int SCALE_DIV = FULL_SCALE_MV / 100;
  localparam int DIG_TO_OUT = 100;

  function automatic int trs_clamp(int v, int lo, int hi);
    if (v > hi) begin
      return hi;
    end
    if (v < lo) begin
      return lo;
    end
    return v;
  endfunction

endpackage

/* trs_ain_chain.sv */
`timescale 1ns/1ps
module trs_ain_chain (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sample_tick,
  input wire logic signed [15:0] sample_mv,
  input wire logic [15:0] filter_time,
  input wire logic signed [15:0] zero_drift,
  input wire logic signed [15:0] offset_mv,
  input wire logic [15:0] dead_zone,
  input wire logic [9:0] full_scale,
  input wire logic auto_zero_en,
  input wire logic drive_stopped,
  output logic signed [15:0] filt_mv,
  output logic signed [31:0] torque,
  output logic out_valid
);

  typedef struct packed {
    logic [5:0] wr;
    logic [6:0] fill;
    logic [6:0] win;
    logic signed [23:0] sum;
    logic busy;
    logic signed [15:0] learned;
    logic signed [15:0] filt_mv;
    logic signed [31:0] torque;
    logic valid;
  } trs_chain_t;

  trs_chain_t r;
  trs_chain_t next_r;
  logic signed [15:0] win_buf [trs_pkg::WIN_DEPTH];
  logic buf_we;

  // ==========================================================
  // moving average, then drift, offset, dead zone, scaling
  always_comb begin
    int win_req;
    int y2;
    int y3;
    int y4;
    int y5;
    int drift;
    int off;
    int dz;
    int fs;
    win_req = 0;
    y2 = 0;
    y3 = 0;
    y4 = 0;
    y5 = 0;
    drift = 0;
    off = 0;
    dz = 0;
    fs = 0;
    next_r = r;
    next_r.valid = 1'b0;
    next_r.busy = 1'b0;
    buf_we = 1'b0;
    // zero time gives a one-slot window, i.e. samples pass unchanged
    win_req = trs_pkg::trs_clamp(int'(filter_time) / trs_pkg::FILTER_STEP_CS, 1,
                                 trs_pkg::WIN_DEPTH);
    if (7'(win_req) != r.win) begin
      next_r.win = 7'(win_req);
      next_r.fill = 7'h00;
      next_r.sum = 24'h00_0000;
      next_r.wr = 6'h00;
    end else if (sample_tick) begin
      buf_we = 1'b1;
      if (r.fill == r.win) begin
        next_r.sum = r.sum + 24'(sample_mv) - 24'(win_buf[r.wr - r.win[5:0]]);
      end else begin
        next_r.sum = r.sum + 24'(sample_mv);
        next_r.fill = r.fill + 7'h01;
      end
      next_r.wr = r.wr + 6'h01;
      next_r.busy = 1'b1;
    end
    if (r.busy && r.fill != 7'h00) begin
      // corrections act on the filter output, not inside it
      y2 = (int'(r.sum) * 10) / int'(r.fill);
      drift = auto_zero_en ? int'(r.learned) :
              trs_pkg::trs_clamp(int'(zero_drift), -trs_pkg::DRIFT_MAX, trs_pkg::DRIFT_MAX);
      y3 = y2 - drift;
      off = trs_pkg::trs_clamp(int'(offset_mv), -trs_pkg::OFFSET_MAX, trs_pkg::OFFSET_MAX) * 10;
      y4 = y3 + off;
      dz = trs_pkg::trs_clamp(int'(dead_zone), 0, trs_pkg::DEAD_MAX);
      y5 = ((y3 - off <= dz) && (off - y3 <= dz)) ? 0 : y4;
      fs = trs_pkg::trs_clamp(int'(full_scale), trs_pkg::FS_MIN, trs_pkg::FS_MAX);
      next_r.torque = 32'((y5 * fs) / trs_pkg::SCALE_DIV);
      next_r.filt_mv = 16'(y2 / 10);
      next_r.valid = 1'b1;
      if (auto_zero_en && drive_stopped) begin
        // learn the idle level as the zero drift
        next_r.learned = 16'(trs_pkg::trs_clamp(y2, -trs_pkg::DRIFT_MAX, trs_pkg::DRIFT_MAX));
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (buf_we) begin
      win_buf[r.wr] <= sample_mv;
    end
  end

  assign filt_mv = r.filt_mv;
  assign torque = r.torque;
  assign out_valid = r.valid;

endmodule

/* trs_torque_ref_select.sv */
`timescale 1ns/1ps
// Operation
// - torque control is active only while the control mode is 2.
// - source 0 A, 1 B, 2 A plus B, 3 A/B swap, 4 communication value.
// - main source A: 0 digital setpoint, 1 analog input one, 2 analog input two.
// - digital setpoint is signed, 0.1 % of rated torque, limited to 300.0 %.
// - each analog sample passes a moving average; zero time passes it unchanged.
// - drift and dead zone are corrected after the filter, not by it.
// - zero drift, up to 500.0 mV, is subtracted from the filtered sample.
// - offset, up to 5000 mV, is added to the drift corrected sample.
// - output zero while input lies within offset plus or minus dead zone.
// - reference is dead zone output over 10000 mV times full scale torque.
// - auto adjust learns zero drift: 0 off, 1 input one, 2 input two.
// - analog input two has the same chain with its own settings.
// - auxiliary source B has the same options under its own selector.
// - in swap mode the swap input active selects A, inactive selects B.
// - communication mode uses the comm value, 0.001 %, limited to 100 %.
// - filtered input one voltage and analog torque are given as monitors.
module trs_torque_ref_select #(
  parameter int SAMPLE_CYCLES = trs_pkg::SAMPLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic drive_running,
  input wire logic [3:0] control_mode_select,
  input wire logic [2:0] torque_ref_source_select,
  input wire logic [1:0] main_torque_src_select,
  input wire logic [1:0] aux_torque_src_select,
  input wire logic signed [15:0] digital_torque_setpoint,
  input wire logic signed [17:0] comm_torque_setpoint,
  input wire logic source_swap_input,
  input wire logic [1:0] analog_auto_zero_select,
  input wire logic signed [15:0] analog_input_one,
  input wire logic [15:0] ain1_filter_time,
  input wire logic signed [15:0] ain1_zero_drift,
  input wire logic signed [15:0] ain1_offset_setting,
  input wire logic [15:0] ain1_dead_zone,
  input wire logic [9:0] torque_at_full_scale,
  input wire logic signed [15:0] analog_input_two,
  input wire logic [15:0] ain2_filter_time,
  input wire logic signed [15:0] ain2_zero_drift,
  input wire logic signed [15:0] ain2_offset_setting,
  input wire logic [15:0] ain2_dead_zone,
  input wire logic [9:0] ain2_torque_at_full_scale,
  output logic signed [31:0] torque_reference,
  output logic torque_ref_strobe,
  output logic torque_mode_active,
  output logic signed [15:0] ain1_sample_monitor,
  output logic signed [31:0] analog_torque_monitor
);

  typedef struct packed {
    logic swap_s1;
    logic swap_s2;
    logic [14:0] div_cnt;
    logic tick;
    logic [2:0] ref_src;
    logic [1:0] main_sel;
    logic [1:0] aux_sel;
    logic [1:0] auto_sel;
    logic [9:0] fs1;
    logic [9:0] fs2;
    logic signed [31:0] torque_reference;
    logic strobe;
    logic active;
    logic signed [15:0] ain1_mon;
    logic signed [31:0] atq_mon;
  } trs_state_t;

  trs_state_t r;
  trs_state_t next_r;

  logic signed [15:0] ch1_filt;
  logic signed [31:0] ch1_torque;
  logic ch1_valid;
  logic signed [31:0] ch2_torque;
  logic signed [31:0] dig_val;
  logic signed [31:0] comm_val;
  logic signed [31:0] a_val;
  logic signed [31:0] b_val;
  logic signed [31:0] sel_val;

  function automatic logic signed [31:0] pick_src(logic [1:0] sel, logic signed [31:0] dig,
                                                   logic signed [31:0] t1,
                                                   logic signed [31:0] t2);
    case (sel)
      trs_pkg::AB_AIN1: begin
        return t1;
      end
      trs_pkg::AB_AIN2: begin
        return t2;
      end
      default: begin
        return dig;
      end
    endcase
  endfunction

  // ==========================================================
  // analog channels
  trs_ain_chain u_ain1 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sample_tick(r.tick),
    .sample_mv(analog_input_one),
    .filter_time(ain1_filter_time),
    .zero_drift(ain1_zero_drift),
    .offset_mv(ain1_offset_setting),
    .dead_zone(ain1_dead_zone),
    .full_scale(r.fs1),
    .auto_zero_en(r.auto_sel == trs_pkg::AUTO_AIN1),
    .drive_stopped(!drive_running),
    .filt_mv(ch1_filt),
    .torque(ch1_torque),
    .out_valid(ch1_valid)
  );

  // second channel with its own settings
  trs_ain_chain u_ain2 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sample_tick(r.tick),
    .sample_mv(analog_input_two),
    .filter_time(ain2_filter_time),
    .zero_drift(ain2_zero_drift),
    .offset_mv(ain2_offset_setting),
    .dead_zone(ain2_dead_zone),
    .full_scale(r.fs2),
    .auto_zero_en(r.auto_sel == trs_pkg::AUTO_AIN2),
    .drive_stopped(!drive_running),
    .filt_mv(),
    .torque(ch2_torque),
    .out_valid()
  );

  // ==========================================================
  // source values, all in 0.001 % of rated torque
  assign dig_val = 32'(trs_pkg::trs_clamp(int'(digital_torque_setpoint),
                  -trs_pkg::DIGITAL_MAX, trs_pkg::DIGITAL_MAX) * trs_pkg::DIG_TO_OUT);
  assign comm_val = 32'(trs_pkg::trs_clamp(int'(comm_torque_setpoint),
                   -trs_pkg::COMM_MAX, trs_pkg::COMM_MAX));
  assign a_val = pick_src(r.main_sel, dig_val, ch1_torque, ch2_torque);
  assign b_val = pick_src(r.aux_sel, dig_val, ch1_torque, ch2_torque);

  always_comb begin
    case (r.ref_src)
      trs_pkg::SRC_B: begin
        sel_val = b_val;
      end
      trs_pkg::SRC_SUM: begin
        sel_val = a_val + b_val;
      end
      trs_pkg::SRC_SWAP: begin
        sel_val = r.swap_s2 ? a_val : b_val;
      end
      trs_pkg::SRC_COMM: begin
        sel_val = comm_val;
      end
      default: begin
        sel_val = a_val;
      end
    endcase
  end

  // ==========================================================
  // state update
  always_comb begin
    next_r = r;
    next_r.strobe = 1'b0;
    next_r.tick = 1'b0;
    next_r.swap_s1 = source_swap_input;
    next_r.swap_s2 = r.swap_s1;
    if (r.div_cnt == 15'(SAMPLE_CYCLES - 1)) begin
      next_r.div_cnt = 15'h0000;
      next_r.tick = 1'b1;
    end else begin
      next_r.div_cnt = r.div_cnt + 15'h0001;
    end
    if (!drive_running) begin
      // stop-only settings are frozen while running
      next_r.ref_src = torque_ref_source_select;
      next_r.main_sel = main_torque_src_select;
      next_r.aux_sel = aux_torque_src_select;
      next_r.auto_sel = analog_auto_zero_select;
      next_r.fs1 = torque_at_full_scale;
      next_r.fs2 = ain2_torque_at_full_scale;
    end
    next_r.active = (control_mode_select == trs_pkg::MODE_TORQUE);
    if (ch1_valid) begin
      next_r.torque_reference = sel_val;
      next_r.strobe = 1'b1;
      next_r.ain1_mon = ch1_filt;
      next_r.atq_mon = ch1_torque;
    end
    if (!next_r.active) begin
      next_r.torque_reference = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.fs1 <= trs_pkg::FS_RESET;
      r.fs2 <= trs_pkg::FS_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign torque_reference = r.torque_reference;
  assign torque_ref_strobe = r.strobe;
  assign torque_mode_active = r.active;
  assign ain1_sample_monitor = r.ain1_mon;
  assign analog_torque_monitor = r.atq_mon;

  // ==========================================================
  // assertions
  property p_mode_gate;
    @(posedge core_clk) disable iff (!rst_n)
    r.strobe |-> r.active == ($past(control_mode_select) == trs_pkg::MODE_TORQUE);
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("mode flag wrong");

  property p_idle_zero;
    @(posedge core_clk) disable iff (!rst_n)
    !r.active |-> r.torque_reference == 32'h0000_0000;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("reference not zero");

  property p_src_a;
    @(posedge core_clk) disable iff (!rst_n)
    ch1_valid && r.ref_src == trs_pkg::SRC_A && control_mode_select == trs_pkg::MODE_TORQUE
    |=> r.strobe && r.torque_reference == $past(a_val);
  endproperty
  a_src_a: assert property (p_src_a) else $error("source A not used");

  property p_sum;
    @(posedge core_clk) disable iff (!rst_n)
    ch1_valid && r.ref_src == trs_pkg::SRC_SUM && control_mode_select == trs_pkg::MODE_TORQUE
    |=> r.torque_reference == $past(a_val) + $past(b_val);
  endproperty
  a_sum: assert property (p_sum) else $error("sum wrong");

  property p_swap;
    @(posedge core_clk) disable iff (!rst_n)
    ch1_valid && r.ref_src == trs_pkg::SRC_SWAP && control_mode_select == trs_pkg::MODE_TORQUE
    |=> r.torque_reference == ($past(source_swap_input, 3) ? $past(a_val) : $past(b_val));
  endproperty
  a_swap: assert property (p_swap) else $error("swap choice wrong");

  property p_comm;
    @(posedge core_clk) disable iff (!rst_n)
    ch1_valid && r.ref_src == trs_pkg::SRC_COMM && control_mode_select == trs_pkg::MODE_TORQUE
    ##1 $stable(comm_torque_setpoint) |-> r.torque_reference == comm_val;
  endproperty
  a_comm: assert property (p_comm) else $error("comm value not used");

  property p_digital;
    @(posedge core_clk) disable iff (!rst_n)
    r.main_sel == trs_pkg::AB_DIGITAL |-> a_val <= 32'sd300000 && a_val >= -32'sd300000;
  endproperty
  a_digital: assert property (p_digital) else $error("digital out of range");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
    drive_running |=> $stable(r.ref_src) && $stable(r.fs1) && $stable(r.main_sel);
  endproperty
  a_hold: assert property (p_hold) else $error("setting changed while running");

  property p_monitor;
    @(posedge core_clk) disable iff (!rst_n)
    ch1_valid |=> r.ain1_mon == $past(ch1_filt) ##1 r.ain1_mon == $past(r.ain1_mon, 1);
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor not updated");

  property p_src_b;
    @(posedge core_clk) disable iff (!rst_n)
    ch1_valid && r.ref_src == trs_pkg::SRC_B && control_mode_select == trs_pkg::MODE_TORQUE
    |=> r.strobe && r.torque_reference == $past(b_val);
  endproperty
  a_src_b: assert property (p_src_b) else $error("source B not used");

  property p_ain2_main;
    @(posedge core_clk) disable iff (!rst_n)
    ch1_valid && r.ref_src == trs_pkg::SRC_A && r.main_sel == trs_pkg::AB_AIN2 &&
    control_mode_select == trs_pkg::MODE_TORQUE
    |=> r.torque_reference == $past(ch2_torque);
  endproperty
  a_ain2_main: assert property (p_ain2_main) else $error("input two not used for A");

  property p_digital_scale;
    @(posedge core_clk) disable iff (!rst_n)
    r.main_sel == trs_pkg::AB_DIGITAL && int'(digital_torque_setpoint) <= trs_pkg::DIGITAL_MAX &&
    int'(digital_torque_setpoint) >= -trs_pkg::DIGITAL_MAX
    |-> int'(a_val) == int'(digital_torque_setpoint) * trs_pkg::DIG_TO_OUT;
  endproperty
  a_digital_scale: assert property (p_digital_scale) else $error("digital scale wrong");

  property p_comm_range;
    @(posedge core_clk) disable iff (!rst_n)
    r.strobe && $past(r.ref_src) == trs_pkg::SRC_COMM
    |-> int'(r.torque_reference) <= trs_pkg::COMM_MAX && int'(r.torque_reference) >= -trs_pkg::COMM_MAX;
  endproperty
  a_comm_range: assert property (p_comm_range) else $error("comm value out of range");

  property p_latch_stopped;
    @(posedge core_clk) disable iff (!rst_n)
    !drive_running |=> r.ref_src == $past(torque_ref_source_select) &&
    r.main_sel == $past(main_torque_src_select);
  endproperty
  a_latch_stopped: assert property (p_latch_stopped) else $error("setting not taken");

  property p_hold_aux;
    @(posedge core_clk) disable iff (!rst_n)
    drive_running |=> $stable(r.aux_sel) && $stable(r.auto_sel) && $stable(r.fs2);
  endproperty
  a_hold_aux: assert property (p_hold_aux) else $error("aux setting changed");

  property p_mode_track;
    @(posedge core_clk) disable iff (!rst_n)
    control_mode_select != trs_pkg::MODE_TORQUE
    |=> !r.active && r.torque_reference == 32'h0000_0000;
  endproperty
  a_mode_track: assert property (p_mode_track) else $error("mode not left");

  property p_atq_mon;
    @(posedge core_clk) disable iff (!rst_n)
    ch1_valid |=> r.atq_mon == $past(ch1_torque);
  endproperty
  a_atq_mon: assert property (p_atq_mon) else $error("torque monitor stale");

  c_sum: cover property (@(posedge core_clk) disable iff (!rst_n)
    r.strobe && r.active && r.ref_src == trs_pkg::SRC_SUM);
  c_swap: cover property (@(posedge core_clk) disable iff (!rst_n)
    r.strobe && r.active && r.ref_src == trs_pkg::SRC_SWAP && !r.swap_s2);
  c_comm: cover property (@(posedge core_clk) disable iff (!rst_n)
    r.strobe && r.active && r.ref_src == trs_pkg::SRC_COMM);
  c_digital: cover property (@(posedge core_clk) disable iff (!rst_n)
    r.strobe && r.active && r.ref_src == trs_pkg::SRC_A && r.main_sel == trs_pkg::AB_DIGITAL);
  c_run_hold: cover property (@(posedge core_clk) disable iff (!rst_n)
    drive_running && r.strobe && r.ref_src != torque_ref_source_select);

endmodule

/* trs_host_model.sv */
`timescale 1ns/1ps
module trs_host_model (
  input wire logic core_clk,
  output logic signed [15:0] ain_one,
  output logic signed [15:0] ain_two,
  output logic swap_pin,
  output logic signed [17:0] comm_value
);
  initial begin
    ain_one = 16'h0000;
    ain_two = 16'h0000;
    swap_pin = 1'b0;
    comm_value = 18'h0_0000;
  end
  // host changes its outputs just after a rising edge
  task automatic drive(input int a1, input int a2, input logic sw, input int cm);
    @(posedge core_clk);
    #2;
    ain_one = 16'(a1);
    ain_two = 16'(a2);
    swap_pin = sw;
    comm_value = 18'(cm);
  endtask
endmodule

/* torque_reference_select_bench.sv */
`timescale 1ns/1ps
module torque_reference_select_bench;
  logic core_clk, rst_n, drive_running, source_swap_input;
  logic [3:0] control_mode_select;
  logic [2:0] torque_ref_source_select;
  logic [1:0] main_torque_src_select, aux_torque_src_select, analog_auto_zero_select;
  logic signed [15:0] digital_torque_setpoint, analog_input_one, analog_input_two;
  logic signed [17:0] comm_torque_setpoint;
  logic [15:0] ain1_filter_time, ain1_dead_zone, ain2_filter_time, ain2_dead_zone;
  logic signed [15:0] ain1_zero_drift, ain1_offset_setting, ain2_zero_drift, ain2_offset_setting;
  logic [9:0] torque_at_full_scale, ain2_torque_at_full_scale;
  logic signed [31:0] torque_reference, analog_torque_monitor;
  logic signed [15:0] ain1_sample_monitor;
  logic torque_ref_strobe, torque_mode_active;
  int num_errors = 0;
  int checked = 0;

  // ==========================================================
  // clock, reset, partner and design
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  trs_host_model host (
    .core_clk(core_clk), .ain_one(analog_input_one), .ain_two(analog_input_two),
    .swap_pin(source_swap_input), .comm_value(comm_torque_setpoint)
  );

  trs_torque_ref_select #(.SAMPLE_CYCLES(8)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .drive_running(drive_running),
    .control_mode_select(control_mode_select),
    .torque_ref_source_select(torque_ref_source_select),
    .main_torque_src_select(main_torque_src_select),
    .aux_torque_src_select(aux_torque_src_select),
    .digital_torque_setpoint(digital_torque_setpoint),
    .comm_torque_setpoint(comm_torque_setpoint), .source_swap_input(source_swap_input),
    .analog_auto_zero_select(analog_auto_zero_select), .analog_input_one(analog_input_one),
    .ain1_filter_time(ain1_filter_time), .ain1_zero_drift(ain1_zero_drift),
    .ain1_offset_setting(ain1_offset_setting), .ain1_dead_zone(ain1_dead_zone),
    .torque_at_full_scale(torque_at_full_scale), .analog_input_two(analog_input_two),
    .ain2_filter_time(ain2_filter_time), .ain2_zero_drift(ain2_zero_drift),
    .ain2_offset_setting(ain2_offset_setting), .ain2_dead_zone(ain2_dead_zone),
    .ain2_torque_at_full_scale(ain2_torque_at_full_scale),
    .torque_reference(torque_reference), .torque_ref_strobe(torque_ref_strobe),
    .torque_mode_active(torque_mode_active), .ain1_sample_monitor(ain1_sample_monitor),
    .analog_torque_monitor(analog_torque_monitor)
  );

  // ==========================================================
  // helpers
  task automatic chk(input string name, input logic signed [31:0] exp, input logic signed [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  // waits for n strobes, looking at settled values on the falling edge
  task automatic strobes(input int n);
    int guard;
    for (int i = 0; i < n; i++) begin
      guard = 0;
      do begin
        @(negedge core_clk);
        guard++;
      end while (torque_ref_strobe !== 1'b1 && guard < 40);
      if (guard >= 40) begin
        chk_bit("strobe", 1'b1, torque_ref_strobe);
      end
    end
  endtask

  // analog chain in 0.1 mV, result in 0.001 % of rated torque
  function automatic int ain_torque(int mv, int drift, int off, int dz, int fs);
    int y3;
    int d;
    y3 = mv * 10 - drift;
    d = y3 - off * 10;
    if (d < 0) begin
      d = -d;
    end
    return (d <= dz) ? 0 : (y3 + off * 10) * fs / 100;
  endfunction

  task automatic setsrc(input int src, input int a, input int b);
    @(posedge core_clk);
    #2;
    torque_ref_source_select = 3'(src);
    main_torque_src_select = 2'(a);
    aux_torque_src_select = 2'(b);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk("ref in reset", 32'h0000_0000, torque_reference);
    chk_bit("strobe in reset", 1'b0, torque_ref_strobe);
  endtask

  task automatic t_digital;
    int sp[3] = '{1234, -3000, 3500};
    int ex[3] = '{123400, -300000, 300000};
    setsrc(0, 0, 1);
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      #2;
      digital_torque_setpoint = 16'(sp[i]);
      strobes(2);
      chk("digital ref", ex[i], torque_reference);
    end
    chk_bit("mode active", 1'b1, torque_mode_active);
  endtask

  task automatic t_sources;
    int b_val;
    b_val = ain_torque(1000, 0, 0, 0, 100);
    @(posedge core_clk);
    #2;
    digital_torque_setpoint = 16'sd50;
    host.drive(1000, 0, 1'b1, 12345);
    for (int s = 0; s < 5; s++) begin
      setsrc(s, 0, 1);
      strobes(2);
      case (s)
        0: chk("src A", 5000, torque_reference);
        1: chk("src B", b_val, torque_reference);
        2: chk("src sum", 5000 + b_val, torque_reference);
        3: chk("swap on", 5000, torque_reference);
        default: chk("comm", 12345, torque_reference);
      endcase
    end
    host.drive(1000, 0, 1'b0, 120000);
    strobes(2);
    chk("comm clamp", 100000, torque_reference);
    setsrc(3, 0, 1);
    strobes(2);
    chk("swap off", b_val, torque_reference);
    chk("ain1 monitor", 1000, 32'(ain1_sample_monitor));
    chk("torque monitor", b_val, analog_torque_monitor);
  endtask

  task automatic t_chain;
    setsrc(0, 2, 0);
    @(posedge core_clk);
    #2;
    ain2_zero_drift = 16'sd50;
    ain2_offset_setting = 16'sd100;
    ain2_dead_zone = 16'd100;
    ain2_torque_at_full_scale = 10'h12c;
    host.drive(0, 2000, 1'b0, 0);
    strobes(2);
    chk("ain2 chain", ain_torque(2000, 50, 100, 100, 300), torque_reference);
    @(posedge core_clk);
    #2;
    ain2_zero_drift = 16'sd0;
    ain2_offset_setting = 16'sd0;
    host.drive(0, 5, 1'b0, 0);
    strobes(2);
    chk("dead zone", 32'h0000_0000, torque_reference);
    host.drive(0, 20, 1'b0, 0);
    strobes(2);
    chk("outside dead zone", ain_torque(20, 0, 0, 100, 300), torque_reference);
  endtask

  task automatic t_filter;
    setsrc(0, 1, 0);
    @(posedge core_clk);
    #2;
    ain1_filter_time = 16'd100;
    host.drive(800, 0, 1'b0, 0);
    strobes(4);
    chk("filter steady", 800, 32'(ain1_sample_monitor));
    host.drive(1600, 0, 1'b0, 0);
    strobes(1);
    chk("filter average", 1200, 32'(ain1_sample_monitor));
    strobes(1);
    chk("filter settled", 1600, 32'(ain1_sample_monitor));
    @(posedge core_clk);
    #2;
    ain1_filter_time = 16'd0;
    analog_auto_zero_select = 2'd1;
    host.drive(300, 0, 1'b0, 0);
    strobes(3);
    chk("auto zero", 32'h0000_0000, torque_reference);
    @(posedge core_clk);
    #2;
    analog_auto_zero_select = 2'd0;
  endtask

  task automatic t_run_lock;
    setsrc(0, 0, 0);
    @(posedge core_clk);
    #2;
    digital_torque_setpoint = 16'sd500;
    host.drive(0, 0, 1'b0, 7000);
    strobes(2);
    @(posedge core_clk);
    #2;
    drive_running = 1'b1;
    setsrc(4, 0, 0);
    strobes(2);
    chk("locked while running", 50000, torque_reference);
    @(posedge core_clk);
    #2;
    digital_torque_setpoint = 16'sd600;
    strobes(2);
    chk("live while running", 60000, torque_reference);
    @(posedge core_clk);
    #2;
    drive_running = 1'b0;
    strobes(2);
    chk("applied when stopped", 7000, torque_reference);
  endtask

  task automatic t_mode;
    @(posedge core_clk);
    #2;
    control_mode_select = 4'h1;
    repeat (20) @(negedge core_clk);
    chk("ref outside mode", 32'h0000_0000, torque_reference);
    chk_bit("mode inactive", 1'b0, torque_mode_active);
  endtask

  // ==========================================================
  // run control
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    drive_running = 1'b0;
    control_mode_select = 4'h2;
    torque_ref_source_select = 3'h0;
    main_torque_src_select = 2'h0;
    aux_torque_src_select = 2'h1;
    analog_auto_zero_select = 2'h0;
    digital_torque_setpoint = 16'h0000;
    ain1_filter_time = 16'h0000;
    ain1_zero_drift = 16'h0000;
    ain1_offset_setting = 16'h0000;
    ain1_dead_zone = 16'h0000;
    torque_at_full_scale = 10'h064;
    ain2_filter_time = 16'h0000;
    ain2_zero_drift = 16'h0000;
    ain2_offset_setting = 16'h0000;
    ain2_dead_zone = 16'h0000;
    ain2_torque_at_full_scale = 10'h064;
    repeat (4) @(posedge core_clk);
    t_reset();
    #2;
    rst_n = 1'b1;
    t_digital();
    t_sources();
    t_chain();
    t_filter();
    t_run_lock();
    t_mode();
    final_report();
  end
endmodule
